//--- sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, irq, serr;
  logic scl_oe, sda_oe, m_oe, scl, sda;
  logic [7:0] paddr, v;
  logic [31:0] pwdata, prdata;
  int num_errors, n_compared;
  assign scl = ~scl_oe;
  assign sda = ~(sda_oe | m_oe);
  twb_ctrl i_dut (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .irq(irq));
  twb_slave_model i_mod (.scl(scl), .sda(sda), .sda_oe(m_oe));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  task automatic stop_test;
    if (num_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 40);
    if (k >= 40) begin
      num_errors++;
      stop_test;
    end
    v = prdata[7:0];
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wait_st(input logic [7:0] m, input logic [7:0] e);
    int k;
    k = 0;
    do begin
      apb(1'h0, 8'h0c, 8'h00);
      k++;
    end while ((v & m) !== e && k < 300);
    if ((v & m) !== e) begin
      num_errors++;
      stop_test;
    end
  endtask
  task automatic go(input logic [7:0] ab, input logic [7:0] st);
    apb(1'h1, 8'h08, 8'hf0);
    wait_st(8'h20, 8'h20);
    apb(1'h1, 8'h10, ab);
    wait_st(8'h80, 8'h80);
    apb(1'h0, 8'h0c, 8'h00);
    chk("addr status", v, st);
    chk("addr byte", i_mod.sh, ab);
    chk("irq", {7'h0, irq}, 8'h01);
    apb(1'h1, 8'h0c, 8'h02);
  endtask
  task automatic stop_bus(input logic [7:0] c);
    apb(1'h1, 8'h08, c);
    wait_st(8'h20, 8'h00);
    apb(1'h1, 8'h0c, 8'h12);
  endtask
  task automatic t_regs;
    apb(1'h0, 8'h08, 8'h00);
    chk("ctrl reset", v, 8'h00);
    apb(1'h1, 8'h08, 8'h9c);
    apb(1'h0, 8'h08, 8'h00);
    chk("ctrl", v, 8'h98);
    apb(1'h0, 8'h0c, 8'h00);
    chk("status", v, 8'h12);
    chk("irq masked", {7'h0, irq}, 8'h00);
    apb(1'h1, 8'h08, 8'hd8);
    chk("irq", {7'h0, irq}, 8'h01);
    apb(1'h1, 8'h0c, 8'h12);
    apb(1'h0, 8'h0c, 8'h00);
    chk("status w1c", v, 8'h00);
    chk("irq clear", {7'h0, irq}, 8'h00);
    apb(1'h1, 8'h18, 8'h55);
    chk("slverr", {7'h0, serr}, 8'h01);
    apb(1'h0, 8'h18, 8'h00);
    chk("unmapped", v, 8'h00);
  endtask
  task automatic t_write;
    go(8'ha4, 8'ha2);
    apb(1'h1, 8'h10, 8'h3c);
    apb(1'h0, 8'h0c, 8'h00);
    chk("busy byte", v & 8'h80, 8'h00);
    wait_st(8'h80, 8'h80);
    chk("tx byte", i_mod.got, 8'h3c);
    chk("ack seen", v & 8'h01, 8'h00);
    stop_bus(8'h90);
  endtask
  task automatic t_read;
    go(8'ha5, 8'ha2);
    apb(1'h0, 8'h10, 8'h00);
    apb(1'h0, 8'h0c, 8'h00);
    chk("no rx", v & 8'h80, 8'h80);
    apb(1'h1, 8'h08, 8'he8);
    apb(1'h0, 8'h10, 8'h00);
    wait_st(8'h80, 8'h80);
    stop_bus(8'hc8);
    apb(1'h0, 8'h10, 8'h00);
    chk("rx byte", v, 8'h5a);
    chk("rx nack", {7'h0, i_mod.nack}, 8'h01);
  endtask
  task automatic t_dis;
    apb(1'h1, 8'h08, 8'h20);
    apb(1'h0, 8'h08, 8'h00);
    chk("dis ctrl", v, 8'h00);
    apb(1'h0, 8'h0c, 8'h00);
    chk("dis status", v & 8'h30, 8'h00);
    apb(1'h1, 8'h08, 8'hf0);
    wait_st(8'h20, 8'h20);
    apb(1'h1, 8'h10, 8'ha4);
    apb(1'h1, 8'h08, 8'h00);
    apb(1'h0, 8'h08, 8'h00);
    chk("dis lines", {6'h0, scl_oe, sda_oe}, 8'h00);
  endtask
  initial begin
    resetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    num_errors = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    repeat (3) @(posedge clk);
    // short quarter bit keeps the run brief
    apb(1'h1, 8'h04, 8'h01);
    t_regs;
    t_write;
    t_read;
    go(8'h20, 8'ha3);
    stop_bus(8'h90);
    t_dis;
    stop_test;
  end
endmodule

//--- sim/twb_ctrl_monitor.sv
`timescale 1ns/10ps
module twb_ctrl_monitor #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic acc, map, cw;
  logic [3:0] off_cnt;
  assign acc = psel && penable;
  assign map = paddr <= 8'h14 && paddr[1:0] == 2'h0;
  assign cw = acc && pwrite && paddr == 8'h08;
  // 4'hf marks enabled; otherwise counts cycles since enable was dropped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      off_cnt <= 4'h0;
    end else if (cw) begin
      off_cnt <= pwdata[7] ? 4'hf : 4'h0;
    end else if (off_cnt < 4'h8) begin
      off_cnt <= off_cnt + 4'h1;
    end
  end
  chk_ready_high: assert property (acc |-> pready) else $error("pready low");
  chk_err_map: assert property (acc |-> pslverr == !map) else $error("pslverr wrong");
  chk_unmap_zero: assert property (acc && !pwrite && !map |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_restart_request_zero: assert property (acc && !pwrite && paddr == 8'h08 |-> !prdata[2])
    else $error("restart bit reads one");
  chk_prdata_hold: assert property (acc |=> $stable(prdata)) else $error("prdata moved");
  chk_irq_gate: assert property (cw && !pwdata[6] |=> !irq)
    else $error("irq while disabled");
  chk_dis_idle: assert property (off_cnt == 4'h8 |-> !scl_oe && !sda_oe)
    else $error("lines driven while disabled");
  chk_start_scl: assert property ($rose(sda_oe) && !scl_oe && scl_in |-> ##[1:300] scl_oe)
    else $error("no clock after start");
  chk_open_drain: assert property (!scl_out && !sda_out) else $error("line driven high");
  cover property (acc && pslverr);
  cover property ($rose(irq));
  cover property ($fell(sda_oe) && !scl_oe && scl_in);
endmodule

bind twb_ctrl twb_ctrl_monitor #(.ADDR_W(ADDR_W)) i_mon (.clk(clk), .resetn(resetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

//--- sim/twb_slave_model.sv
`timescale 1ns/10ps
module twb_slave_model #(
  parameter logic [6:0] SADDR = 7'h52,
  parameter logic [7:0] TXD = 8'h5a
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe
);
  logic act, adr, sel, rd, nack;
  logic [7:0] sh, got;
  int p;
  initial begin
    sda_oe = 1'h0;
    act = 1'h0;
    sel = 1'h0;
    p = 0;
  end
  always @(negedge sda) begin
    if (scl === 1'h1) begin
      act = 1'h1;
      adr = 1'h1;
      sel = 1'h0;
      p = 0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'h1) begin
      act = 1'h0;
      sda_oe = 1'h0;
    end
  end
  always @(posedge scl) begin
    if (act) begin
      if (p < 8) sh = {sh[6:0], sda};
      else nack = sda;
      p = p + 1;
    end
  end
  // changes sda only while scl is low so no false start or stop is seen
  always @(negedge scl) begin
    if (act && p == 8) begin
      if (adr) begin
        rd = sh[0];
        sel = sh[7:1] == SADDR;
      end else if (sel && !rd) got = sh;
      sda_oe = sel && (adr || !rd);
    end else if (act && p == 9) begin
      p = 0;
      adr = 1'h0;
      if (nack) sel = 1'h0;
      sda_oe = sel && rd && !TXD[7];
    end else if (act && p > 0) sda_oe = sel && rd && !adr && !TXD[7 - p];
  end
endmodule

//--- verilog/twb_consts.svh
// Operation
// R1: module works only while module_enable_bit set
// R2: irq_enable_bit gates the interrupt request
// R3: master_select rise starts, fall stops
// R4: direction_select picks receive or transmit
// R5: software matches direction to slave_rw_status
// R6: ack_suppress sets receiver acknowledge level
// R7: restart_request repeats start, reads zero
// R8: misplaced repeated start means arbitration lost
// R9: byte_done_flag set per byte, cleared by access
// R10: addressed_flag on match, cleared by control write
// R11: busy set by start, cleared by stop
// R12: arb_lost_flag set on loss, write one clears
// R13: slave_rw_status holds received read/write bit
// R14: irq_pending_flag set by events, write one clears
// R15: ack_received_status zero means acknowledge seen
// R16: master transmit data write sends byte, msb first
// R17: master receive data read starts next byte
// R18: leave receive mode before final data read
// R19: slave mode triggers transfers like master mode
// R20: transfer starts only when direction matches access
// R21: data read returns last received byte
// R22: first byte after master select is address
// R23: nine clocks per byte, ack on ninth
// R24: start and stop are sda edges, scl high
// R25: arbitration loser releases sda, becomes slave
// R26: irq high when pending and enabled
// R27: disabled module releases lines, stays idle
`ifndef TWB_CONSTS_SVH
`define TWB_CONSTS_SVH
`define TWB_OFS_ADDR 8'h00
`define TWB_OFS_DIV 8'h04
`define TWB_OFS_CTRL 8'h08
`define TWB_OFS_STAT 8'h0c
`define TWB_OFS_DATA 8'h10
`define TWB_OFS_CTRL2 8'h14
`define TWB_C_EN 7
`define TWB_C_IE 6
`define TWB_C_MST 5
`define TWB_C_TX 4
`define TWB_C_ACK_SUPPRESS 3
`define TWB_C_RESTART_REQUEST 2
`define TWB_S_ARB_LOST_FLAG 4
`define TWB_S_IIF 1
`define TWB_C2_GC 7
`define TWB_DIV_RST 8'h3e
`define TWB_ADDR_RST 7'h00
`define TWB_GC_ADDR 8'h00
`endif

//--- verilog/twb_ctrl.sv
`timescale 1ns/10ps
`include "twb_consts.svh"
module twb_ctrl #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic irq
);
  twb_pkg::twb_regs_type s;
  twb_pkg::twb_regs_type n;
  logic [1:0] rst_ff;
  logic rst_n;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic tick;
  logic adv;
  logic last;
  logic acc;
  logic wr;
  logic rd;
  logic set_tcf;
  logic set_iif;
  logic set_arb_lost_flag;
  logic set_addressed_flag;
  logic clr_tcf;
  logic clr_iif;
  logic clr_arb_lost_flag;
  logic clr_addressed_flag;
  logic [7:0] rd_val;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, `TWB_OFS_ADDR) | hit(a, `TWB_OFS_DIV) | hit(a, `TWB_OFS_CTRL) |
             hit(a, `TWB_OFS_STAT) | hit(a, `TWB_OFS_DATA) | hit(a, `TWB_OFS_CTRL2);
  endfunction

  // reset enters asynchronously, leaves in step with clk
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_ff <= 2'b00;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_ff[1];

  twb_line_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .scl_pin(scl_in),
    .sda_pin(sda_in),
    .scl(scl),
    .sda(sda),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
  );

  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;

  always_comb begin
    if (hit(paddr, `TWB_OFS_ADDR)) begin
      rd_val = {s.saddr, 1'b0};
    end else if (hit(paddr, `TWB_OFS_DIV)) begin
      rd_val = s.div;
    end else if (hit(paddr, `TWB_OFS_CTRL)) begin
      rd_val = {s.en, s.ie, s.master_select, s.tx, s.ack_suppress, 3'h0}; // R7
    end else if (hit(paddr, `TWB_OFS_STAT)) begin
      rd_val = {s.byte_done_flag, s.addressed_flag, s.busy, s.arb_lost_flag, 1'b0, s.slave_rw_status, s.iif, s.ack_received_status}; // R15
    end else if (hit(paddr, `TWB_OFS_DATA)) begin
      rd_val = s.rxd; // R21
    end else if (hit(paddr, `TWB_OFS_CTRL2)) begin
      rd_val = {s.gcen, 7'h00};
    end else begin
      rd_val = 8'h00;
    end
  end

  always_comb begin
    n = s;
    set_tcf = 1'b0;
    set_iif = 1'b0;
    set_arb_lost_flag = 1'b0;
    set_addressed_flag = 1'b0;
    // one tick per quarter bit; scl line low period stretches by waiting in phase 2
    tick = (s.cnt == 8'h00);
    n.cnt = tick ? s.div : s.cnt - 8'h01;
    adv = tick && ((s.phase != 2'd2) || scl);
    last = (s.bitn == 4'd8);
    if (start_seen) begin
      n.busy = 1'b1; // R11
    end
    if (stop_seen) begin
      n.busy = 1'b0; // R11
    end

    case (s.state)
      twb_pkg::st_idle: begin
        n.kick = 1'b0;
        if (start_seen) begin
          n.state = twb_pkg::st_saddr;
          n.bitn = 4'd0;
        end
      end
      // also serves the repeated start: sda is released in phase 0 first
      twb_pkg::st_start: begin
        if (adv) begin
          n.phase = s.phase + 2'd1;
          case (s.phase)
            2'd0: n.sda_drv = 1'b0;
            2'd1: n.scl_drv = 1'b0;
            2'd2: n.sda_drv = 1'b1; // R24
            default: begin
              n.scl_drv = 1'b1;
              n.state = twb_pkg::st_hold;
            end
          endcase
        end
      end
      twb_pkg::st_stop: begin
        if (adv) begin
          n.phase = s.phase + 2'd1;
          case (s.phase)
            2'd0: n.sda_drv = 1'b1;
            2'd1: n.scl_drv = 1'b0;
            default: begin
              n.sda_drv = 1'b0; // R24
              n.own = 1'b0;
              n.state = twb_pkg::st_idle;
            end
          endcase
        end
      end
      twb_pkg::st_hold: begin
        n.sda_drv = 1'b0;
        if (s.own && !s.master_select) begin
          n.state = twb_pkg::st_stop; // R3
          n.phase = 2'd0;
        end else if (s.kick) begin
          n.kick = 1'b0;
          n.bitn = 4'd0;
          n.phase = 2'd0;
          if (s.own) begin
            n.state = twb_pkg::st_mbit;
          end else begin
            n.state = twb_pkg::st_sbit; // R19
            n.scl_drv = 1'b0;
            n.sda_drv = s.tx & ~s.sh[7];
          end
        end
      end
      twb_pkg::st_mbit: begin
        if (adv) begin
          n.phase = s.phase + 2'd1;
          case (s.phase)
            2'd0: begin
              if (last) begin
                n.sda_drv = ~s.tx & ~s.ack_suppress; // R6 R23
              end else begin
                n.sda_drv = s.tx & ~s.sh[7]; // R16 R4
              end
            end
            2'd1: n.scl_drv = 1'b0;
            2'd2: begin
              if (last) begin
                if (s.tx) begin
                  n.ack_received_status = sda; // R15
                end
              end else if (s.tx && s.sh[7] && !sda) begin
                // lost while sending a one: go quiet; keep listening as slave during the address byte, otherwise go idle
                set_arb_lost_flag = 1'b1; // R25
                set_iif = 1'b1;
                n.master_select = 1'b0;
                n.own = 1'b0;
                n.sda_drv = 1'b0;
                n.scl_drv = 1'b0;
                n.sh = {s.sh[6:0], sda};
                n.bitn = s.bitn + 4'd1;
                n.state = s.first ? twb_pkg::st_saddr : twb_pkg::st_idle; // R25
              end else begin
                n.sh = {s.sh[6:0], sda};
              end
            end
            default: begin
              n.scl_drv = 1'b1;
              if (last) begin
                set_tcf = 1'b1; // R9
                set_iif = 1'b1; // R14
                n.sda_drv = 1'b0;
                n.first = 1'b0; // R22
                if (!s.tx) begin
                  n.rxd = s.sh;
                end
                n.state = twb_pkg::st_hold;
              end else begin
                n.bitn = s.bitn + 4'd1;
              end
            end
          endcase
        end
      end
      twb_pkg::st_saddr: begin
        if (scl_rise && !s.bitn[3]) begin
          n.sh = {s.sh[6:0], sda};
          n.bitn = s.bitn + 4'd1;
        end else if (scl_fall && last) begin
          if ((s.sh[7:1] == s.saddr) || (s.gcen && s.sh == `TWB_GC_ADDR)) begin
            set_addressed_flag = 1'b1; // R10
            set_iif = 1'b1; // R14
            set_tcf = 1'b1;
            n.slave_rw_status = s.sh[0]; // R13
            n.sda_drv = 1'b1;
            n.bitn = 4'd9;
          end else begin
            n.state = twb_pkg::st_idle;
          end
        end else if (scl_fall && s.bitn == 4'd9) begin
          // hold scl low until software reacts to the match
          n.sda_drv = 1'b0;
          n.scl_drv = 1'b1;
          n.state = twb_pkg::st_hold;
        end
      end
      twb_pkg::st_sbit: begin
        if (scl_rise) begin
          if (!last) begin
            n.sh = {s.sh[6:0], sda};
          end else if (s.tx) begin
            n.ack_received_status = sda; // R15
          end
        end else if (scl_fall) begin
          if (last) begin
            set_tcf = 1'b1; // R9
            set_iif = 1'b1; // R14
            n.sda_drv = 1'b0;
            if (!s.tx) begin
              n.rxd = s.sh;
            end
            if (s.tx && s.ack_received_status) begin
              n.state = twb_pkg::st_idle;
            end else begin
              n.scl_drv = 1'b1;
              n.state = twb_pkg::st_hold;
            end
          end else begin
            n.bitn = s.bitn + 4'd1;
            if (s.bitn == 4'd7) begin
              n.sda_drv = ~s.tx & ~s.ack_suppress; // R6 R23
            end else begin
              n.sda_drv = s.tx & ~s.sh[7]; // R4
            end
          end
        end
      end
      default: n.state = twb_pkg::st_idle;
    endcase

    // as slave, bus start/stop abandon the current byte
    if (!s.own && s.state != twb_pkg::st_idle) begin
      if (stop_seen) begin
        n.state = twb_pkg::st_idle;
        n.sda_drv = 1'b0;
        n.scl_drv = 1'b0;
      end else if (start_seen) begin
        n.state = twb_pkg::st_saddr;
        n.bitn = 4'd0;
        n.sda_drv = 1'b0;
        n.scl_drv = 1'b0;
      end
    end

    clr_tcf = (rd & hit(paddr, `TWB_OFS_DATA) & ~s.tx) |
              (wr & hit(paddr, `TWB_OFS_DATA) & s.tx); // R9
    clr_addressed_flag = wr & hit(paddr, `TWB_OFS_CTRL); // R10
    clr_arb_lost_flag = wr & hit(paddr, `TWB_OFS_STAT) & pwdata[`TWB_S_ARB_LOST_FLAG]; // R12
    clr_iif = wr & hit(paddr, `TWB_OFS_STAT) & pwdata[`TWB_S_IIF]; // R14

    if (psel && !penable) begin
      n.prdata = rd_val;
    end
    if (wr && hit(paddr, `TWB_OFS_ADDR)) begin
      n.saddr = pwdata[7:1];
    end
    if (wr && hit(paddr, `TWB_OFS_DIV)) begin
      n.div = pwdata[7:0];
    end
    if (wr && hit(paddr, `TWB_OFS_CTRL2)) begin
      n.gcen = pwdata[`TWB_C2_GC];
    end
    if (wr && hit(paddr, `TWB_OFS_CTRL)) begin
      n.en = pwdata[`TWB_C_EN];
      n.ie = pwdata[`TWB_C_IE];
      n.tx = pwdata[`TWB_C_TX];
      n.ack_suppress = pwdata[`TWB_C_ACK_SUPPRESS];
      if (pwdata[`TWB_C_MST] && !s.master_select) begin
        if (s.busy || s.state != twb_pkg::st_idle) begin
          set_arb_lost_flag = 1'b1;
          set_iif = 1'b1;
        end else begin
          n.master_select = 1'b1; // R3
          n.own = 1'b1;
          n.first = 1'b1; // R22
          n.phase = 2'd0;
          n.state = twb_pkg::st_start;
        end
      end else if (!pwdata[`TWB_C_MST]) begin
        n.master_select = 1'b0; // R3
        // a restart asked for without being master is misplaced
        if (pwdata[`TWB_C_RESTART_REQUEST]) begin
          set_arb_lost_flag = 1'b1; // R8
          set_iif = 1'b1;
        end
      end else if (pwdata[`TWB_C_RESTART_REQUEST]) begin
        if (s.own && s.state == twb_pkg::st_hold) begin
          n.first = 1'b1; // R7
          n.phase = 2'd0;
          n.state = twb_pkg::st_start;
        end else begin
          set_arb_lost_flag = 1'b1; // R8
          set_iif = 1'b1;
          n.master_select = 1'b0;
          n.own = 1'b0;
          n.sda_drv = 1'b0;
          n.scl_drv = 1'b0;
          n.state = twb_pkg::st_idle;
        end
      end
    end
    // data only loads between bytes; a write mid-byte still requests the next one
    if (wr && hit(paddr, `TWB_OFS_DATA) && s.tx) begin
      n.kick = 1'b1; // R16 R20
      if (s.state != twb_pkg::st_mbit && s.state != twb_pkg::st_sbit) begin
        n.sh = pwdata[7:0];
      end
    end
    if (rd && hit(paddr, `TWB_OFS_DATA) && !s.tx) begin
      n.kick = 1'b1; // R17 R20
    end

    // hardware set beats a same-cycle software clear
    n.byte_done_flag = (s.byte_done_flag & ~clr_tcf) | set_tcf;
    n.addressed_flag = (s.addressed_flag & ~clr_addressed_flag) | set_addressed_flag;
    n.arb_lost_flag = (s.arb_lost_flag & ~clr_arb_lost_flag) | set_arb_lost_flag; // R12
    n.iif = (s.iif & ~clr_iif) | set_iif; // R14

    if (!n.en) begin
      n.state = twb_pkg::st_idle; // R1 R27
      n.scl_drv = 1'b0;
      n.sda_drv = 1'b0;
      n.master_select = 1'b0;
      n.own = 1'b0;
      n.kick = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.state <= twb_pkg::st_idle;
      s.div <= `TWB_DIV_RST;
      s.saddr <= `TWB_ADDR_RST;
    end else begin
      s <= n;
    end
  end

  assign prdata = {24'h000000, s.prdata};
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped(paddr);
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = s.scl_drv;
  assign sda_oe = s.sda_drv;
  assign irq = s.iif & s.ie; // R2 R26
endmodule

//--- verilog/twb_line_sync.sv
`timescale 1ns/10ps
module twb_line_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic scl,
  output logic sda,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen
);
  twb_pkg::twb_sync_type s;
  twb_pkg::twb_sync_type n;

  // first stage feeds only the second; edges compare stages two and three
  always_comb begin
    n = s;
    n.scl_m = scl_pin;
    n.scl_s = s.scl_m;
    n.scl_d = s.scl_s;
    n.sda_m = sda_pin;
    n.sda_s = s.sda_m;
    n.sda_d = s.sda_s;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= 6'h3f;
    end else begin
      s <= n;
    end
  end

  assign scl = s.scl_s;
  assign sda = s.sda_s;
  assign scl_rise = s.scl_s & ~s.scl_d;
  assign scl_fall = ~s.scl_s & s.scl_d;
  assign start_seen = s.scl_s & s.scl_d & s.sda_d & ~s.sda_s; // R24
  assign stop_seen = s.scl_s & s.scl_d & ~s.sda_d & s.sda_s; // R24
endmodule

//--- verilog/twb_pkg.sv
package twb_pkg;
  typedef enum logic [6:0] {
    st_idle = 7'h01,
    st_start = 7'h02,
    st_hold = 7'h04,
    st_mbit = 7'h08,
    st_stop = 7'h10,
    st_saddr = 7'h20,
    st_sbit = 7'h40
  } twb_state_type;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
  } twb_sync_type;

  typedef struct packed {
    logic en;
    logic ie;
    logic master_select;
    logic tx;
    logic ack_suppress;
    logic gcen;
    logic [6:0] saddr;
    logic [7:0] div;
    logic byte_done_flag;
    logic addressed_flag;
    logic busy;
    logic arb_lost_flag;
    logic slave_rw_status;
    logic iif;
    logic ack_received_status;
    logic [7:0] rxd;
    logic [7:0] sh;
    twb_state_type state;
    logic [1:0] phase;
    logic [3:0] bitn;
    logic [7:0] cnt;
    logic scl_drv;
    logic sda_drv;
    logic own;
    logic first;
    logic kick;
    logic [7:0] prdata;
  } twb_regs_type;
endpackage
